// file: rtl/cct_pkg.sv
// Constants shared by the capture/compare timer core: register map, field
// positions, reset values and mode encodings.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr[7:0].
package cct_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL_ONE_LOW  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CTRL_TWO_HIGH = 8'h08;
  localparam logic [7:0] ADDR_STATUS_LOW    = 8'h0C;
  localparam logic [7:0] ADDR_COUNTER_LOW   = 8'h10;
  localparam logic [7:0] ADDR_COUNTER_HIGH  = 8'h14;
  localparam logic [7:0] ADDR_PERIOD_LOW    = 8'h18;
  localparam logic [7:0] ADDR_PERIOD_HIGH   = 8'h1C;
  localparam logic [7:0] ADDR_COMPARE_A     = 8'h20;
  localparam logic [7:0] ADDR_COMPARE_B     = 8'h24;
  localparam logic [7:0] ADDR_CAPTURE_BUF   = 8'h28;

  // Control one low fields
  localparam int CTRL_EN_BIT     = 15;
  localparam int CLKSEL_LSB      = 8;
  localparam int WIDE_BIT        = 5;
  localparam int CAPTURE_COMPARE_SELECT_BIT       = 4;
  localparam int MODE_LSB        = 0;
  // Control one high fields
  localparam int TRIGGER_ENABLE_BIT      = 7;
  localparam int SYNC_LSB        = 0;
  // Control two high fields
  localparam int AUX_LSB         = 3;
  localparam int CAPDIS_BIT      = 0;
  // Status low fields
  localparam int STAT_TRIG_BIT   = 7;
  localparam int STAT_TRIGGER_CLEAR_BIT  = 5;
  localparam int STAT_OVF_BIT    = 3;
  localparam int STAT_EMPTY_BIT  = 2;
  localparam int STAT_FULL_BIT   = 1;
  localparam int STAT_OUT_BIT    = 0;

  // Reset values
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [31:0] DWORD_RST  = 32'h0000_0000;
  localparam logic [15:0] WORD_MAX   = 16'hFFFF;
  localparam logic [31:0] DWORD_MAX  = 32'hFFFF_FFFF;

  // Clock source select
  localparam logic [2:0] CLK_SYS = 3'h0;

  // Sync source codes
  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_OWN  = 5'h01;
  localparam logic [4:0] SYNC_AUTO = 5'h1F;

  // Mode select encodings
  typedef enum logic [3:0] {
    CCT_M_TIMER  = 4'h0,
    CCT_M_HIGH   = 4'h1,
    CCT_M_LOW    = 4'h2,
    CCT_M_TOGGLE = 4'h3,
    CCT_M_DUAL   = 4'h4,
    CCT_M_PWM    = 4'h5,
    CCT_M_CENTER = 4'h6,
    CCT_M_VFREQ  = 4'h7
  } cct_mode_e;

  // Auxiliary output select
  localparam logic [1:0] AUX_OFF  = 2'h0;
  localparam logic [1:0] AUX_ROLL = 2'h1;
  localparam logic [1:0] AUX_EVT  = 2'h2;
  localparam logic [1:0] AUX_SIG  = 2'h3;

endpackage : cct_pkg

// file: rtl/cct_sync_edge.sv
// Two-stage synchroniser with edge detection for a group of inputs.
// Assumes inputs are asynchronous to clk_i; edges come from stages two and three.
`timescale 1ns/1ps
module cct_sync_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Raw inputs
  input  wire logic [W-1:0] d_i,
  // Synchronised level and edges
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Synchroniser chain; stage one feeds stage two only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges seen once per transition
  assign lvl_o  = s2_q;
  assign rise_o = s2_q & ~s3_q;
  assign fall_o = ~s2_q & s3_q;

endmodule : cct_sync_edge

// file: rtl/cct_core.sv
// Capture/compare timer core: dual 16-bit or 32-bit time base, sync and
// trigger start, output compare and PWM, input capture into a FIFO, aux output.
// Assumes a classic Wishbone master on clk_i; all pin inputs are asynchronous.
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module cct_core #(
  parameter int  FIFO_DEPTH = 4,
  parameter bit  MULTI_OUT  = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Time base sources for select codes 1 to 7
  input  wire logic [6:0]  timebase_src_i,
  // Sync sources indexed by sync code
  input  wire logic [31:0] sync_src_i,
  // Capture pin
  input  wire logic        capture_i,
  // Outputs to other modules
  output logic             sync_o,
  output logic             compare_event_flag_o,
  output logic             compare_out_o,
  output logic             aux_o
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // Structural check on the FIFO depth
  if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  // Merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Synchronised pins
  logic [39:0] pin_lvl;
  logic [39:0] pin_rise;
  logic [39:0] pin_fall;

  cct_sync_edge #(.W(40)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    ({capture_i, sync_src_i, timebase_src_i}),
    .lvl_o  (pin_lvl),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  // State registers
  logic           ack_q, ack_d;
  logic [31:0]    dat_q, dat_d;
  logic           en_q, en_d;
  logic [2:0]     clksel_q, clksel_d;
  logic           wide_q, wide_d;
  logic           capture_compare_select_q, capture_compare_select_d;
  logic [3:0]     mode_q, mode_d;
  logic           trigger_enable_q, trigger_enable_d;
  logic [4:0]     syncsel_q, syncsel_d;
  logic [1:0]     auxsel_q, auxsel_d;
  logic           capdis_q, capdis_d;
  logic           trig_q, trig_d;
  logic           ovf_q, ovf_d;
  logic [15:0]    lo_q, lo_d, hi_q, hi_d;
  logic [15:0]    prl_q, prl_d, prh_q, prh_d;
  logic [31:0]    ra_q, ra_d, rb_q, rb_d;
  logic [15:0]    ras_q, ras_d, rbs_q, rbs_d;
  logic           out_q, out_d;
  logic [3:0]     pre_q, pre_d;
  logic           sync_q, sync_d;
  logic           cef_q, cef_d;
  logic           aux_q, aux_d;
  logic [31:0]    fifo_q [FIFO_DEPTH];
  logic [31:0]    fifo_d [FIFO_DEPTH];
  logic [PW-1:0]  wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]    fcnt_q, fcnt_d;

  // Combinational helpers
  logic        acc, wr, rd, tick, sevt, run, roll, sec_roll, trigger_clear;
  logic        mat_a, mat_b, cmp_evt, cap_evt, push, pop, fifo_full;
  logic [31:0] cnt32, lim32, rdv, wv;
  logic [15:0] lim_lo;

  // Next-state logic for bus, time base, compare and capture
  always_comb begin
    ack_d = 1'b0; dat_d = dat_q; en_d = en_q; clksel_d = clksel_q; wide_d = wide_q;
    capture_compare_select_d = capture_compare_select_q; mode_d = mode_q; trigger_enable_d = trigger_enable_q; syncsel_d = syncsel_q;
    auxsel_d = auxsel_q; capdis_d = capdis_q; trig_d = trig_q; ovf_d = ovf_q;
    lo_d = lo_q; hi_d = hi_q; prl_d = prl_q; prh_d = prh_q; ra_d = ra_q; rb_d = rb_q;
    ras_d = ras_q; rbs_d = rbs_q; out_d = out_q; pre_d = pre_q;
    fifo_d = fifo_q; wp_d = wp_q; rp_d = rp_q; fcnt_d = fcnt_q;
    // Bus access takes one cycle, answered by a one-cycle ack
    acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = acc & wb_we_i;
    rd = acc & ~wb_we_i;
    wv = cct_pkg::DWORD_RST;
    trigger_clear = wr && wb_adr_i == cct_pkg::ADDR_STATUS_LOW && wb_sel_i[0] && wb_dat_i[cct_pkg::STAT_TRIGGER_CLEAR_BIT];
    // Time base clock as a one-cycle enable
    tick = (clksel_q == cct_pkg::CLK_SYS) ? 1'b1 : pin_rise[clksel_q - 3'd1];
    // Own sync out feeds back; none and auto codes give no event; other codes come from pins
    unique case (syncsel_q)
      cct_pkg::SYNC_NONE, cct_pkg::SYNC_AUTO: sevt = 1'b0;
      cct_pkg::SYNC_OWN:                      sevt = sync_q;
      default:                                sevt = pin_rise[7 + syncsel_q];
    endcase
    run = en_q & tick & ~(trigger_enable_q & ~trig_q);
    cnt32 = {hi_q, lo_q};
    lim_lo = (capture_compare_select_q || syncsel_q == cct_pkg::SYNC_AUTO) ? cct_pkg::WORD_MAX : prl_q;
    lim32 = (capture_compare_select_q || syncsel_q == cct_pkg::SYNC_AUTO) ? cct_pkg::DWORD_MAX : {prh_q, prl_q};
    roll = run & (wide_q ? (cnt32 == lim32) : (lo_q == lim_lo));
    sec_roll = en_q & tick & ~wide_q & ~capture_compare_select_q & (hi_q == prh_q);
    // Counting
    if (run) begin
      if (wide_q) begin
        {hi_d, lo_d} = roll ? cct_pkg::DWORD_RST : cnt32 + 32'h0000_0001;
      end else begin
        lo_d = roll ? cct_pkg::WORD_RST : lo_q + 16'h0001;
      end
    end
    if (en_q && tick && !wide_q && !capture_compare_select_q) begin
      hi_d = sec_roll ? cct_pkg::WORD_RST : hi_q + 16'h0001;
    end
    // Sync reset of the primary timer
    if (sevt && !trigger_enable_q) begin
      lo_d = cct_pkg::WORD_RST;
      if (wide_q) begin
        hi_d = cct_pkg::WORD_RST;
      end
    end
    // Clear or trigger wait holds the timer at zero; a trigger in the clear cycle still wins
    if (trigger_clear || (trigger_enable_q && !trig_q)) begin
      trig_d = 1'b0;
      lo_d = cct_pkg::WORD_RST;
      if (wide_q) begin
        hi_d = cct_pkg::WORD_RST;
      end
    end
    if (trigger_enable_q && sevt) begin
      trig_d = 1'b1;
    end
    // Compare matches taken on the time base tick
    mat_a = run & (wide_q ? (cnt32 == ra_q) : (lo_q == ra_q[15:0]));
    mat_b = run & (lo_q == rb_q[15:0]);
    cmp_evt = 1'b0;
    if (roll) begin
      ras_d = ra_q[15:0];
      rbs_d = rb_q[15:0];
    end
    if (!capture_compare_select_q) begin
      unique case (mode_q)
        cct_pkg::CCT_M_TIMER: out_d = 1'b0;
        cct_pkg::CCT_M_HIGH: begin
          cmp_evt = mat_a;
          out_d = mat_a ? 1'b1 : out_q;
        end
        cct_pkg::CCT_M_LOW: begin
          cmp_evt = mat_a;
          out_d = mat_a ? 1'b0 : out_q;
        end
        cct_pkg::CCT_M_TOGGLE: begin
          cmp_evt = mat_a;
          out_d = out_q ^ mat_a;
        end
        cct_pkg::CCT_M_DUAL: begin
          cmp_evt = mat_a | mat_b;
          if (mat_a) out_d = 1'b1;
          if (mat_b) out_d = 1'b0;
        end
        cct_pkg::CCT_M_PWM, cct_pkg::CCT_M_CENTER: begin
          // Shadow values only change at rollover, so no glitch mid-period
          if (mode_q == cct_pkg::CCT_M_CENTER && !MULTI_OUT) begin
            out_d = 1'b0;
          end else begin
            cmp_evt = run & ((lo_q == ras_q) | (lo_q == rbs_q));
            if (run && lo_q == ras_q) out_d = 1'b1;
            if (run && lo_q == rbs_q) out_d = 1'b0;
          end
        end
        cct_pkg::CCT_M_VFREQ: begin
          cmp_evt = roll;
          out_d = out_q ^ roll;
        end
        default: out_d = 1'b0;
      endcase
    end else begin
      out_d = 1'b0;
    end
    // Capture event selection and prescale
    cap_evt = 1'b0;
    if (capture_compare_select_q && en_q) begin
      unique case (mode_q)
        4'h0, 4'h3: cap_evt = pin_rise[39] | pin_fall[39];
        4'h1:       cap_evt = pin_rise[39];
        4'h2:       cap_evt = pin_fall[39];
        4'h4, 4'h5: begin
          if (pin_rise[39]) begin
            pre_d = pre_q + 4'h1;
          end
          cap_evt = pin_rise[39] & ((mode_q == 4'h4) ? (pre_q[1:0] == 2'h3) : (pre_q == 4'hF));
        end
        default:    cap_evt = 1'b0;
      endcase
    end
    // FIFO pop on buffer read, push on capture
    fifo_full = (fcnt_q == (PW+1)'(FIFO_DEPTH));
    pop = rd && wb_adr_i == cct_pkg::ADDR_CAPTURE_BUF && fcnt_q != '0;
    push = cap_evt & ~capdis_q & (~fifo_full | pop);
    if (cap_evt && !capdis_q && fifo_full && !pop) begin
      ovf_d = 1'b1;
    end else if (wr && wb_adr_i == cct_pkg::ADDR_STATUS_LOW && wb_sel_i[0] && wb_dat_i[cct_pkg::STAT_OVF_BIT]) begin
      ovf_d = 1'b0;
    end
    if (push) begin
      fifo_d[wp_q] = wide_q ? cnt32 : {cct_pkg::WORD_RST, lo_q};
      wp_d = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
    fcnt_d = fcnt_q + (PW+1)'(push) - (PW+1)'(pop);
    // Read data
    rdv = cct_pkg::DWORD_RST;
    unique case (wb_adr_i)
      cct_pkg::ADDR_CTRL_ONE_LOW: begin
        rdv[cct_pkg::CTRL_EN_BIT] = en_q;
        rdv[cct_pkg::CLKSEL_LSB +: 3] = clksel_q;
        rdv[cct_pkg::WIDE_BIT] = wide_q;
        rdv[cct_pkg::CAPTURE_COMPARE_SELECT_BIT] = capture_compare_select_q;
        rdv[cct_pkg::MODE_LSB +: 4] = mode_q;
      end
      cct_pkg::ADDR_CTRL_ONE_HIGH: begin
        rdv[cct_pkg::TRIGGER_ENABLE_BIT] = trigger_enable_q;
        rdv[cct_pkg::SYNC_LSB +: 5] = syncsel_q;
      end
      cct_pkg::ADDR_CTRL_TWO_HIGH: begin
        rdv[cct_pkg::AUX_LSB +: 2] = auxsel_q;
        rdv[cct_pkg::CAPDIS_BIT] = capdis_q;
      end
      cct_pkg::ADDR_STATUS_LOW: begin
        rdv[cct_pkg::STAT_TRIG_BIT] = trig_q;
        rdv[cct_pkg::STAT_OVF_BIT] = ovf_q;
        rdv[cct_pkg::STAT_EMPTY_BIT] = (fcnt_q == '0);
        rdv[cct_pkg::STAT_FULL_BIT] = fifo_full;
        rdv[cct_pkg::STAT_OUT_BIT] = out_q;
      end
      cct_pkg::ADDR_COUNTER_LOW:  rdv[15:0] = lo_q;
      cct_pkg::ADDR_COUNTER_HIGH: rdv[15:0] = hi_q;
      cct_pkg::ADDR_PERIOD_LOW:   rdv[15:0] = prl_q;
      cct_pkg::ADDR_PERIOD_HIGH:  rdv[15:0] = prh_q;
      cct_pkg::ADDR_COMPARE_A:    rdv = ra_q;
      cct_pkg::ADDR_COMPARE_B:    rdv = rb_q;
      cct_pkg::ADDR_CAPTURE_BUF:  rdv = (fcnt_q != '0) ? fifo_q[rp_q] : cct_pkg::DWORD_RST;
      default:                    rdv = cct_pkg::DWORD_RST;
    endcase
    if (acc) begin
      ack_d = 1'b1;
      dat_d = wb_we_i ? cct_pkg::DWORD_RST : rdv;
    end
    // Register writes; software counter writes override counting
    if (wr) begin
      wv = merge(rdv, wb_dat_i, wb_sel_i);
      unique case (wb_adr_i)
        cct_pkg::ADDR_CTRL_ONE_LOW: begin
          en_d = wv[cct_pkg::CTRL_EN_BIT];
          clksel_d = wv[cct_pkg::CLKSEL_LSB +: 3];
          wide_d = wv[cct_pkg::WIDE_BIT];
          capture_compare_select_d = wv[cct_pkg::CAPTURE_COMPARE_SELECT_BIT];
          mode_d = wv[cct_pkg::MODE_LSB +: 4];
        end
        cct_pkg::ADDR_CTRL_ONE_HIGH: begin
          trigger_enable_d = wv[cct_pkg::TRIGGER_ENABLE_BIT];
          syncsel_d = wv[cct_pkg::SYNC_LSB +: 5];
        end
        cct_pkg::ADDR_CTRL_TWO_HIGH: begin
          auxsel_d = wv[cct_pkg::AUX_LSB +: 2];
          capdis_d = wv[cct_pkg::CAPDIS_BIT];
        end
        cct_pkg::ADDR_COUNTER_LOW:  lo_d = wv[15:0];
        cct_pkg::ADDR_COUNTER_HIGH: hi_d = wv[15:0];
        cct_pkg::ADDR_PERIOD_LOW:   prl_d = wv[15:0];
        cct_pkg::ADDR_PERIOD_HIGH:  prh_d = wv[15:0];
        cct_pkg::ADDR_COMPARE_A:    ra_d = wv;
        cct_pkg::ADDR_COMPARE_B:    rb_d = wv;
        default: ;
      endcase
    end
    // Output pulses and aux selection
    sync_d = roll;
    cef_d = ((sec_roll | (wide_q & ~capture_compare_select_q & roll)) & (mode_q == cct_pkg::CCT_M_TIMER)) | cmp_evt;
    aux_d = 1'b0;
    if (auxsel_q != cct_pkg::AUX_OFF) begin
      if (capture_compare_select_q) begin
        aux_d = (auxsel_q == cct_pkg::AUX_ROLL) ? roll : (auxsel_q == cct_pkg::AUX_EVT) & capdis_q;
      end else if (mode_q == cct_pkg::CCT_M_TIMER) begin
        aux_d = (auxsel_q == cct_pkg::AUX_ROLL) ? roll : (auxsel_q == cct_pkg::AUX_EVT) & sevt;
      end else begin
        unique case (auxsel_q)
          cct_pkg::AUX_ROLL: aux_d = roll;
          cct_pkg::AUX_EVT:  aux_d = cmp_evt;
          default:           aux_d = out_d;
        endcase
      end
    end
  end

  // State registers with synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0; dat_q <= cct_pkg::DWORD_RST; en_q <= 1'b0; clksel_q <= cct_pkg::CLK_SYS;
      wide_q <= 1'b0; capture_compare_select_q <= 1'b0; mode_q <= cct_pkg::CCT_M_TIMER; trigger_enable_q <= 1'b0;
      syncsel_q <= cct_pkg::SYNC_NONE; auxsel_q <= cct_pkg::AUX_OFF; capdis_q <= 1'b0;
      trig_q <= 1'b0; ovf_q <= 1'b0; lo_q <= cct_pkg::WORD_RST; hi_q <= cct_pkg::WORD_RST;
      prl_q <= cct_pkg::WORD_MAX; prh_q <= cct_pkg::WORD_MAX;
      ra_q <= cct_pkg::DWORD_RST; rb_q <= cct_pkg::DWORD_RST;
      ras_q <= cct_pkg::WORD_RST; rbs_q <= cct_pkg::WORD_RST; out_q <= 1'b0; pre_q <= 4'h0;
      sync_q <= 1'b0; cef_q <= 1'b0; aux_q <= 1'b0;
      wp_q <= '0; rp_q <= '0; fcnt_q <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) fifo_q[i] <= cct_pkg::DWORD_RST;
    end else begin
      ack_q <= ack_d; dat_q <= dat_d; en_q <= en_d; clksel_q <= clksel_d;
      wide_q <= wide_d; capture_compare_select_q <= capture_compare_select_d; mode_q <= mode_d; trigger_enable_q <= trigger_enable_d;
      syncsel_q <= syncsel_d; auxsel_q <= auxsel_d; capdis_q <= capdis_d;
      trig_q <= trig_d; ovf_q <= ovf_d; lo_q <= lo_d; hi_q <= hi_d;
      prl_q <= prl_d; prh_q <= prh_d; ra_q <= ra_d; rb_q <= rb_d;
      ras_q <= ras_d; rbs_q <= rbs_d; out_q <= out_d; pre_q <= pre_d;
      sync_q <= sync_d; cef_q <= cef_d; aux_q <= aux_d;
      wp_q <= wp_d; rp_q <= rp_d; fcnt_q <= fcnt_d;
      fifo_q <= fifo_d;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sync_o = sync_q;
  assign compare_event_flag_o = cef_q;
  assign compare_out_o = out_q;
  assign aux_o = aux_q;

endmodule : cct_core

// file: verif/cct_core_monitor.sv
// Port checker for cct_core: bus handshake, aux and compare output.
// Assumes a bind into cct_core; control fields shadowed from bus writes.
`timescale 1ns/1ps
module cct_core_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Module outputs
  input wire logic        sync_o,
  input wire logic        compare_event_flag_o,
  input wire logic        compare_out_o,
  input wire logic        aux_o
);
  logic [5:0] ct_q, ct_d;
  logic [4:0] ax_q, ax_d;
  logic [1:0] age_q, age_d;
  logic       wr, cfg, tmr;
  // Shadow fields; age keeps checks off while a change settles
  always_comb begin
    wr    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    ct_d  = (wr && wb_adr_i == cct_pkg::ADDR_CTRL_ONE_LOW) ? wb_dat_i[5:0] : ct_q;
    ax_d  = (wr && wb_adr_i == cct_pkg::ADDR_CTRL_TWO_HIGH) ? wb_dat_i[4:0] : ax_q;
    age_d = wr ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
    cfg   = age_q == 2'h3;
    tmr   = ct_q[4:0] == 5'h00;
  end
  // Shadow registers
  always_ff @(posedge clk_i) begin
    ct_q  <= rst_i ? 6'h00 : ct_d;
    ax_q  <= rst_i ? 5'h00 : ax_d;
    age_q <= rst_i ? 2'h0 : age_d;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_wr_zero; wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data not zero");
  property p_aux_off; cfg && ax_q[4:3] == cct_pkg::AUX_OFF |-> !aux_o; endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux while off");
  property p_tb_none; cfg && tmr && ax_q[4:3] == cct_pkg::AUX_SIG |-> !aux_o; endproperty
  a_tb_none: assert property (p_tb_none) else $error("aux in time base");
  property p_cap_aux; cfg && ct_q[4] && ax_q[4:3] == cct_pkg::AUX_EVT |-> aux_o == ax_q[0]; endproperty
  a_cap_aux: assert property (p_cap_aux) else $error("aux not disable bit");
  property p_cmp_aux;
    cfg && !ct_q[4] && !tmr && ax_q[4:3] == cct_pkg::AUX_SIG && $stable(compare_out_o) |-> aux_o == compare_out_o;
  endproperty
  a_cmp_aux: assert property (p_cmp_aux) else $error("aux not compare");
  property p_plain_low; cfg && tmr |-> !compare_out_o; endproperty
  a_plain_low: assert property (p_plain_low) else $error("output in timer mode");
  c_flag: cover property (compare_event_flag_o);
  c_sync: cover property (sync_o);
  c_aux: cover property (aux_o);
endmodule : cct_core_monitor
bind cct_core cct_core_monitor cct_core_monitor_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sync_o, .compare_event_flag_o, .compare_out_o, .aux_o);

// file: verif/cct_src_model.sv
// Sync sources and capture pin of the surrounding chip.
// Assumes the caller starts each task between clock edges.
`timescale 1ns/1ps
module cct_src_model (
  // Clock
  input  wire logic        clk_i,
  // Sync sources and capture pin
  output logic      [31:0] sync_src_o,
  output logic             capture_o
);
  // Idle sources low until commanded
  initial begin
    sync_src_o = 32'h0000_0000;
    capture_o  = 1'b0;
  end
  // Long pulse: a level-sensitive core would restart repeatedly
  task automatic sync_pulse(input int code, input int len);
    @(posedge clk_i);
    sync_src_o[code] <= 1'b1;
    repeat (len) @(posedge clk_i);
    sync_src_o[code] <= 1'b0;
  endtask : sync_pulse
  // Flip pin, then let it pass the synchroniser
  task automatic cap_flip();
    @(posedge clk_i);
    capture_o <= ~capture_o;
    repeat (5) @(posedge clk_i);
  endtask : cap_flip
endmodule : cct_src_model

// file: verif/cct_core_test.sv
// Testbench for cct_core: bus, timer, sync, trigger, compare, capture.
// Assumes cct_core of rtl/ and the source model beside it.
`timescale 1ns/1ps
module cct_core_test;
  localparam logic [7:0] CT = cct_pkg::ADDR_CTRL_ONE_LOW;
  localparam logic [7:0] C1 = cct_pkg::ADDR_CTRL_ONE_HIGH;
  localparam logic [7:0] C2 = cct_pkg::ADDR_CTRL_TWO_HIGH;
  localparam logic [7:0] ST = cct_pkg::ADDR_STATUS_LOW;
  localparam logic [7:0] TL = cct_pkg::ADDR_COUNTER_LOW;
  localparam logic [7:0] TH = cct_pkg::ADDR_COUNTER_HIGH;
  localparam logic [7:0] PL = cct_pkg::ADDR_PERIOD_LOW;
  localparam logic [7:0] PH = cct_pkg::ADDR_PERIOD_HIGH;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [6:0]  tbs   = 7'h00;
  logic [31:0] rdat, ss, q, q2;
  logic        ack, syn, cef, cout, aux, cap;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Design and its surroundings; external time base pins driven by the bench
  cct_core cct_core_i (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timebase_src_i(tbs),
    .sync_src_i(ss), .capture_i(cap), .sync_o(syn), .compare_event_flag_o(cef), .compare_out_o(cout), .aux_o(aux));
  cct_src_model cct_src_model_i (.clk_i, .sync_src_o(ss), .capture_o(cap));
  // Clock and hang guard
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // Classic cycle: hold until ack is sampled high, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    req <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    check($sformatf("reg %h", a), q, e);
  endtask : rdc
  task automatic t_reset();
    rdc(CT, 32'h0000_0000);
    rdc(PL, 32'h0000_FFFF);
    wr(8'h3C, 32'h0000_1234);
    rdc(8'h3C, 32'h0000_0000);
  endtask : t_reset
  // Primary every 5 ticks, secondary every 4, over 40 cycles
  task automatic t_dual();
    int ns, nf;
    ns = 0;
    nf = 0;
    wr(PH, 32'h0000_0003);
    wr(PL, 32'h0000_0004);
    wr(C2, 32'h0000_0018);
    wr(CT, 32'h0000_8000);
    repeat (40) begin
      @(posedge clk_i);
      ns += int'(syn === 1'b1);
      nf += int'(cef === 1'b1);
    end
    check("flag pulses", nf, 10);
    check("sync pulses", ns, 8);
  endtask : t_dual
  task automatic t_wide();
    wr(CT, 32'h0000_0020);
    wr(PL, 32'h0000_FFFF);
    wr(PH, 32'h0000_FFFF);
    wr(TL, 32'h0000_FFFE);
    wr(TH, 32'h0000_0005);
    wr(CT, 32'h0000_8020);
    repeat (6) @(posedge clk_i);
    rdc(TH, 32'h0000_0006);
  endtask : t_wide
  task automatic t_sync();
    wr(CT, 32'h0000_0000);
    wr(C1, 32'h0000_0002);
    wr(CT, 32'h0000_8000);
    cct_src_model_i.sync_pulse(2, 20);
    bus(1'b0, TL, 32'h0000_0000, q);
    check("restart count", q >= 12 && q <= 30, 1);
  endtask : t_sync
  task automatic t_trig();
    wr(CT, 32'h0000_0000);
    wr(C1, 32'h0000_0083);
    wr(CT, 32'h0000_8000);
    rdc(TL, 32'h0000_0000);
    rdc(ST, 32'h0000_0004);
    cct_src_model_i.sync_pulse(3, 4);
    rdc(ST, 32'h0000_0084);
    bus(1'b0, TL, 32'h0000_0000, q);
    check("running", q != 0, 1);
    wr(ST, 32'h0000_0020);
    rdc(ST, 32'h0000_0004);
    rdc(TL, 32'h0000_0000);
    rdc(TL, 32'h0000_0000);
  endtask : t_trig
  // High, low, toggle, toggle: mode set while stopped, so each must move the held output
  task automatic t_cmp();
    logic [3:0] md [4] = '{4'h1, 4'h2, 4'h3, 4'h3};
    logic       ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(C1, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(CT, {28'h0000_000, md[i]});
      wr(cct_pkg::ADDR_COMPARE_A, 32'h0000_0014);
      wr(TL, 32'h0000_0000);
      wr(CT, {28'h0000_800, md[i]});
      repeat (40) @(posedge clk_i);
      bus(1'b0, ST, 32'h0000_0000, q);
      check("compare out", q[0], ex[i]);
      check("compare pin", cout, ex[i]);
    end
  endtask : t_cmp
  task automatic t_cap();
    wr(CT, 32'h0000_8010);
    cct_src_model_i.cap_flip();
    cct_src_model_i.cap_flip();
    rdc(ST, 32'h0000_0000);
    bus(1'b0, cct_pkg::ADDR_CAPTURE_BUF, 32'h0000_0000, q2);
    bus(1'b0, cct_pkg::ADDR_CAPTURE_BUF, 32'h0000_0000, q);
    check("later capture", q > q2, 1);
    rdc(ST, 32'h0000_0004);
    wr(CT, 32'h0000_8011);
    cct_src_model_i.cap_flip();
    cct_src_model_i.cap_flip();
    bus(1'b0, cct_pkg::ADDR_CAPTURE_BUF, 32'h0000_0000, q);
    rdc(ST, 32'h0000_0004);
    wr(C2, 32'h0000_0011);
    repeat (8) @(posedge clk_i);
  endtask : t_cap
  // Time base from an external pin: three rises, three counts
  task automatic t_clk();
    wr(CT, 32'h0000_0000);
    wr(TL, 32'h0000_0000);
    wr(CT, 32'h0000_8100);
    repeat (6) begin
      @(posedge clk_i);
      tbs[0] <= ~tbs[0];
      repeat (3) @(posedge clk_i);
    end
    rdc(TL, 32'h0000_0003);
  endtask : t_clk
  // Five edges into four slots, then every 4th rise only
  task automatic t_full();
    wr(C2, 32'h0000_0000);
    wr(CT, 32'h0000_8013);
    repeat (5) cct_src_model_i.cap_flip();
    rdc(ST, 32'h0000_000A);
    wr(ST, 32'h0000_0008);
    rdc(ST, 32'h0000_0002);
    repeat (4) bus(1'b0, cct_pkg::ADDR_CAPTURE_BUF, 32'h0000_0000, q);
    wr(CT, 32'h0000_8014);
    repeat (14) cct_src_model_i.cap_flip();
    rdc(ST, 32'h0000_0000);
    bus(1'b0, cct_pkg::ADDR_CAPTURE_BUF, 32'h0000_0000, q);
    rdc(ST, 32'h0000_0004);
  endtask : t_full
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_dual();
    t_wide();
    t_sync();
    t_trig();
    t_cmp();
    t_clk();
    t_cap();
    t_full();
    wrap_up();
  end
endmodule : cct_core_test
